// *** verilog/rbq_pkg.sv ***
package rbq_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_SEC = 12;
    localparam int NUM_CH = 4;
    localparam int NUM_COEF = 5;
    localparam int DW = 24;
    localparam int CW = 32;
    localparam int FRAC = 31;

    // ****************************************
    // Coefficient register map
    // ****************************************
    localparam logic [3:0] PAGE_LO = 4'h8;
    localparam logic [3:0] PAGE_HI = 4'h9;
    localparam logic [6:0] COEF_BASE_REG = 7'h08;
    localparam logic [6:0] SEC_REGS = 7'h14;
    localparam logic [3:0] SEC_PER_PAGE = 4'h6;
    localparam logic [2:0] IDX_N0 = 3'h0;
    localparam logic [2:0] IDX_N1 = 3'h1;
    localparam logic [2:0] IDX_N2 = 3'h2;
    localparam logic [2:0] IDX_D1 = 3'h3;
    localparam logic [2:0] IDX_D2 = 3'h4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] N0_RST = 32'h7fffffff;
    localparam logic [31:0] COEF_RST = 32'h00000000;
    localparam logic [1:0] ALLOC_RST = 2'h2;
    localparam logic [1:0] ALLOC_BYPASS = 2'h0;

    typedef enum logic [0:0] {
        RBQ_IDLE = 1'b0,
        RBQ_RUN = 1'b1
    } rbq_state_e;
endpackage

// *** verilog/rbq_section.sv ***
// One biquad step, purely combinational; history lives in the caller
module rbq_section (
    input wire logic signed [23:0] x_i,
    input wire logic signed [23:0] x1_i,
    input wire logic signed [23:0] x2_i,
    input wire logic signed [23:0] y1_i,
    input wire logic signed [23:0] y2_i,
    input wire logic [4:0][31:0] coef_i,
    output logic signed [23:0] y_o
);
    logic signed [59:0] acc;
    logic signed [28:0] quo;

    // ****************************************
    // 2^31 y = N0 x + 2N1 x1 + N2 x2 + 2D1 y1 + D2 y2
    // ****************************************
    always_comb begin
        // Widen each operand first so no product is cut at 32 bits
        acc = 60'(signed'(coef_i[rbq_pkg::IDX_N0])) * 60'(x_i)
            + 60'(signed'(coef_i[rbq_pkg::IDX_N1])) * 60'(x1_i) * 60'sd2
            + 60'(signed'(coef_i[rbq_pkg::IDX_N2])) * 60'(x2_i)
            + 60'(signed'(coef_i[rbq_pkg::IDX_D1])) * 60'(y1_i) * 60'sd2
            + 60'(signed'(coef_i[rbq_pkg::IDX_D2])) * 60'(y2_i);
        // Round to nearest so the reset gain 1-2^-31 returns x exactly
        acc = acc + 60'sh000000040000000;
        quo = acc[59:rbq_pkg::FRAC];
        // Saturate rather than wrap; a wrapped IIR output rings badly
        if (quo > 29'sh07fffff) begin
            y_o = 24'sh7fffff;
        end else if (quo < -29'sh0800000) begin
            y_o = -24'sh800000;
        end else begin
            y_o = quo[23:0];
        end
    end
endmodule

// *** verilog/rbq_filter_bank.sv ***
// How it works
// - Twelve sections, three at most per channel
// - Each section is a two-pole two-zero IIR
// - Reset coefficients give flat unity gain
// - Two banks for channels 1-2 in two-channel mode, switch bit selects
// - Allocation 00 bypasses every channel
// - Allocation 01: sections 1-4 to channels 1-4
// - Allocation 10: sections 1-8, two per channel
// - Allocation 11: all twelve, three per channel
// - Twenty registers per section, pages 8 and 9
module rbq_filter_bank (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [1:0] record_biquad_allocation_i,
    input wire logic two_ch_mode_i,
    input wire logic bank_sel_i,
    input wire logic coef_wr_i,
    input wire logic [3:0] coef_page_i,
    input wire logic [6:0] coef_addr_i,
    input wire logic [7:0] coef_data_i,
    input wire logic in_valid_i,
    input wire logic [1:0] in_ch_i,
    input wire logic signed [23:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [1:0] out_ch_o,
    output logic signed [23:0] out_data_o
);
    // ****************************************
    // Storage and sequencer state
    // ****************************************
    logic [4:0][31:0] coef_ff [rbq_pkg::NUM_SEC];
    logic signed [23:0] x1_ff [rbq_pkg::NUM_SEC];
    logic signed [23:0] x2_ff [rbq_pkg::NUM_SEC];
    logic signed [23:0] y1_ff [rbq_pkg::NUM_SEC];
    logic signed [23:0] y2_ff [rbq_pkg::NUM_SEC];
    rbq_pkg::rbq_state_e state_ff;
    logic [1:0] stage_ff;
    logic [1:0] n_ff;
    logic [1:0] ch_ff;
    logic bank_ff;
    logic two_ch_ff;
    logic signed [23:0] x_ff;
    logic signed [23:0] cur_ff;
    logic out_valid_ff;
    logic signed [23:0] out_data_ff;
    logic [1:0] ch_eff;
    logic [3:0] sec_idx;
    logic signed [23:0] sec_y;
    logic accept;
    logic wr_hit;
    logic [6:0] wr_off;
    logic [3:0] wr_sec;
    logic [4:0] wr_byte;
    logic [2:0] wr_word;
    logic [1:0] wr_lane;

    assign in_ready_o = (state_ff == rbq_pkg::RBQ_IDLE);
    assign accept = ce_i && in_valid_i && in_ready_o;
    assign out_valid_o = out_valid_ff;
    assign out_data_o = out_data_ff;
    assign out_ch_o = ch_ff;

    // ****************************************
    // Coefficient write decode
    // ****************************************
    // Section = (reg-8)/20 on its page, then word and byte inside it
    always_comb begin
        wr_off = coef_addr_i - rbq_pkg::COEF_BASE_REG;
        wr_hit = coef_wr_i && (coef_addr_i >= rbq_pkg::COEF_BASE_REG)
            && (coef_page_i == rbq_pkg::PAGE_LO || coef_page_i == rbq_pkg::PAGE_HI);
        wr_sec = 4'(wr_off / rbq_pkg::SEC_REGS);
        if (coef_page_i == rbq_pkg::PAGE_HI) begin
            wr_sec = wr_sec + rbq_pkg::SEC_PER_PAGE;
        end
        wr_byte = 5'(wr_off % rbq_pkg::SEC_REGS);
        wr_word = 3'(wr_byte / 5'd4);
        wr_lane = 2'd3 - wr_byte[1:0];
    end

    // One coefficient bank per section; writes land byte by byte
    for (genvar g = 0; g < rbq_pkg::NUM_SEC; g++) begin : g_coef
        always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
                coef_ff[g] <= {rbq_pkg::COEF_RST, rbq_pkg::COEF_RST, rbq_pkg::COEF_RST,
                    rbq_pkg::COEF_RST, rbq_pkg::N0_RST};
            end else if (ce_i && wr_hit && wr_sec == 4'(g)) begin
                coef_ff[g][wr_word][wr_lane*8 +: 8] <= coef_data_i;
            end
        end
    end

    // ****************************************
    // Section selection
    // ****************************************
    // Alternate bank borrows the sections of channel+2 in two-channel use
    assign ch_eff = (two_ch_ff && bank_ff && !ch_ff[1]) ? ch_ff + 2'd2 : ch_ff;
    assign sec_idx = {stage_ff, ch_eff};

    rbq_section u_section (
        .x_i(cur_ff),
        .x1_i(x1_ff[sec_idx]),
        .x2_i(x2_ff[sec_idx]),
        .y1_i(y1_ff[sec_idx]),
        .y2_i(y2_ff[sec_idx]),
        .coef_i(coef_ff[sec_idx]),
        .y_o(sec_y)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    // Allocation and bank are sampled once per sample, never mid-cascade
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= rbq_pkg::RBQ_IDLE;
            stage_ff <= 2'h0;
            n_ff <= rbq_pkg::ALLOC_RST;
            ch_ff <= 2'h0;
            bank_ff <= 1'b0;
            two_ch_ff <= 1'b0;
            x_ff <= 24'sh000000;
            cur_ff <= 24'sh000000;
        end else if (ce_i) begin
            unique case (state_ff)
                rbq_pkg::RBQ_IDLE: begin
                    if (accept) begin
                        n_ff <= record_biquad_allocation_i;
                        ch_ff <= in_ch_i;
                        bank_ff <= bank_sel_i;
                        two_ch_ff <= two_ch_mode_i;
                        x_ff <= in_data_i;
                        cur_ff <= in_data_i;
                        stage_ff <= 2'h0;
                        if (record_biquad_allocation_i != rbq_pkg::ALLOC_BYPASS) begin
                            state_ff <= rbq_pkg::RBQ_RUN;
                        end
                    end
                end
                rbq_pkg::RBQ_RUN: begin
                    cur_ff <= sec_y;
                    if (stage_ff == n_ff - 2'd1) begin
                        state_ff <= rbq_pkg::RBQ_IDLE;
                    end else begin
                        stage_ff <= stage_ff + 2'd1;
                    end
                end
            endcase
        end
    end

    // History update of the section just used
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < rbq_pkg::NUM_SEC; i++) begin
                x1_ff[i] <= 24'sh000000;
                x2_ff[i] <= 24'sh000000;
                y1_ff[i] <= 24'sh000000;
                y2_ff[i] <= 24'sh000000;
            end
        end else if (ce_i && state_ff == rbq_pkg::RBQ_RUN) begin
            x1_ff[sec_idx] <= cur_ff;
            x2_ff[sec_idx] <= x1_ff[sec_idx];
            y1_ff[sec_idx] <= sec_y;
            y2_ff[sec_idx] <= y1_ff[sec_idx];
        end
    end

    // Output register; bypass answers the cycle after acceptance
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= 24'sh000000;
        end else if (ce_i) begin
            out_valid_ff <= 1'b0;
            if (accept && record_biquad_allocation_i == rbq_pkg::ALLOC_BYPASS) begin
                out_valid_ff <= 1'b1;
                out_data_ff <= in_data_i;
            end else if (state_ff == rbq_pkg::RBQ_RUN && stage_ff == n_ff - 2'd1) begin
                out_valid_ff <= 1'b1;
                out_data_ff <= sec_y;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    bypass_pass_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        out_valid_o && n_ff == rbq_pkg::ALLOC_BYPASS |-> out_data_o == x_ff)
        else $error("bypass changed the sample");
    stage_count_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        out_valid_o && n_ff != rbq_pkg::ALLOC_BYPASS |-> stage_ff == n_ff - 2'd1)
        else $error("cascade length differs from allocation");
    max_three_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == rbq_pkg::RBQ_RUN |-> stage_ff < 2'd3 && sec_idx < 4'd12)
        else $error("section beyond twelve or stage beyond three");
    one_stage_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        accept && record_biquad_allocation_i == 2'h1 ##1 ce_i |=> out_valid_o)
        else $error("single section cascade not done in one step");
    reset_gain_a: assert property (@(posedge sys_clk_i)
        rst_i |=> coef_ff[0][rbq_pkg::IDX_N0] == rbq_pkg::N0_RST
            && coef_ff[11][rbq_pkg::IDX_D2] == rbq_pkg::COEF_RST)
        else $error("coefficients not at unity reset");
    byte_order_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && coef_wr_i && coef_page_i == rbq_pkg::PAGE_HI && coef_addr_i == 7'h1c
        |=> coef_ff[7][rbq_pkg::IDX_N0][31:24] == $past(coef_data_i))
        else $error("register 28 of page 9 not top byte of section 8 N0");
    bank_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == rbq_pkg::RBQ_RUN && $past(state_ff) == rbq_pkg::RBQ_RUN
        |-> bank_ff == $past(bank_ff) && n_ff == $past(n_ff))
        else $error("bank changed inside a sample");
    bank_map_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == rbq_pkg::RBQ_RUN && two_ch_ff && bank_ff && ch_ff == 2'h0
        |-> sec_idx[1:0] == 2'h2)
        else $error("alternate bank not selected");
    bypass_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        out_valid_o && n_ff == rbq_pkg::ALLOC_BYPASS);
    three_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        out_valid_o && n_ff == 2'h3);
    bank_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        state_ff == rbq_pkg::RBQ_RUN && two_ch_ff && bank_ff);
endmodule

// *** sim/rbq_host_model.sv ***
// Host side: loads coefficient bytes over the byte write port
module rbq_host_model (
    input wire logic sys_clk_i,
    output logic coef_wr_o,
    output logic [3:0] coef_page_o,
    output logic [6:0] coef_addr_o,
    output logic [7:0] coef_data_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle lines at time zero
    initial begin
        coef_wr_o = 1'b0;
        coef_page_o = 4'h0;
        coef_addr_o = 7'h00;
        coef_data_o = 8'h00;
    end

    // One word as four bytes, top byte first; loaded before samples need it
    task automatic wr(input logic [3:0] pg, input int sec, input int idx,
                      input logic [31:0] v);
        for (int b = 0; b < 4; b++) begin
            @(negedge sys_clk_i);
            coef_wr_o = 1'b1;
            coef_page_o = pg;
            coef_addr_o = 7'(8 + 20 * sec + 4 * idx + b);
            coef_data_o = v[31 - 8 * b -: 8];
        end
        @(negedge sys_clk_i);
        // Released address and data lines never keep the last value, so stale bytes show up; page keeps its value
        coef_wr_o = 1'b0;
        coef_addr_o = ~coef_addr_o;
        coef_data_o = ~coef_data_o;
    endtask
endmodule

// *** sim/tb_rbq_filter_bank.sv ***
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module tb_rbq_filter_bank;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk_i, rst_i, ce_i, two_ch_mode_i, bank_sel_i, in_valid_i, stall;
    logic coef_wr, in_ready_o, out_valid_o;
    logic [1:0] alloc, in_ch_i, out_ch_o;
    logic [3:0] coef_page;
    logic [6:0] coef_addr;
    logic [7:0] coef_data;
    logic signed [23:0] in_data_i, out_data_o, prev1, x;
    logic signed [23:0] qd[$];
    logic [1:0] qc[$];
    int ql[$], qa[$];
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;

    rbq_filter_bank i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .record_biquad_allocation_i(alloc), .two_ch_mode_i(two_ch_mode_i),
        .bank_sel_i(bank_sel_i), .coef_wr_i(coef_wr), .coef_page_i(coef_page),
        .coef_addr_i(coef_addr), .coef_data_i(coef_data), .in_valid_i(in_valid_i),
        .in_ch_i(in_ch_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
        .out_valid_o(out_valid_o), .out_ch_o(out_ch_o), .out_data_o(out_data_o));
    rbq_host_model i_host (.sys_clk_i(sys_clk_i), .coef_wr_o(coef_wr),
        .coef_page_o(coef_page), .coef_addr_o(coef_addr), .coef_data_o(coef_data));

    // ****************************************
    // Clock, clock enable, reference math
    // ****************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // Random stalls prove delays count only enabled cycles
    always @(negedge sys_clk_i) ce_i <= stall ? ($urandom % 4 != 0) : 1'b1;

    // Half gain plus half feedback, rounded half up; 25 bits avoid overflow
    function automatic logic signed [23:0] hf(logic signed [23:0] v, p);
        logic signed [24:0] t;
        t = {v[23], v} + {p[23], p} + 25'sh1;
        return t[24:1];
    endfunction

    // Halving sections: 1 (ch 0), 7 (ch 2), 8 (ch 3), 9 (ch 0)
    function automatic logic signed [23:0] exp_of(int a, int c, logic signed [23:0] v);
        if (c == 0 && a == 3) return hf(hf(v, 24'sh0), 24'sh0);
        if ((c == 0 && a != 0) || (c >= 2 && a >= 2)) return hf(v, 24'sh0);
        return v;
    endfunction

    // ****************************************
    // Driver and monitor
    // ****************************************
    task automatic results();
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Request held until taken; expectation noted as it is offered
    task automatic send(input int a, input logic tc, bk, input logic [1:0] ch,
                        input logic signed [23:0] xv, e);
        int n;
        @(negedge sys_clk_i);
        alloc = 2'(a);
        two_ch_mode_i = tc;
        bank_sel_i = bk;
        in_valid_i = 1'b1;
        in_ch_i = ch;
        in_data_i = xv;
        qd.push_back(e);
        qc.push_back(ch);
        ql.push_back(a == 0 ? 1 : a + 1);
        for (n = 0; n < 60; n++) begin
            @(posedge sys_clk_i);
            if (in_ready_o === 1'b1 && ce_i) break;
        end
        if (n == 60) begin
            num_errors++;
            results();
        end
    endtask

    task automatic idle();
        @(negedge sys_clk_i);
        in_valid_i = 1'b0;
    endtask

    // Oldest note against each result, delay in enabled cycles
    always @(posedge sys_clk_i) begin
        if (!rst_i && ce_i) begin
            if (in_valid_i && in_ready_o) qa.push_back(cyc);
            if (out_valid_o && qd.size() == 0) `CHK("spare out", 1'b0, 1'b1)
            else if (out_valid_o) begin
                `CHK("out_data", qd[0], out_data_o)
                `CHK("out_ch", qc[0], out_ch_o)
                `CHK("latency", ql[0], cyc - qa[0])
                qd.delete(0);
                qc.delete(0);
                ql.delete(0);
                qa.delete(0);
            end
            cyc++;
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int a, c, p;
        rst_i = 1'b1;
        ce_i = 1'b1;
        stall = 1'b0;
        alloc = 2'h2;
        two_ch_mode_i = 1'b0;
        bank_sel_i = 1'b0;
        in_valid_i = 1'b0;
        in_ch_i = 2'h0;
        in_data_i = 24'sh0;
        prev1 = 24'sh0;
        void'($urandom(64));
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        `CHK("ready", 1'b1, in_ready_o)
        `CHK("valid", 1'b0, out_valid_o)
        `CHK("data", 24'sh0, out_data_o)
        // Pass 0 default coefficients, pass 1 four halving sections
        for (p = 0; p < 2; p++) begin
            if (p == 1) begin
                idle();
                i_host.wr(4'h8, 0, 0, 32'h40000000);
                i_host.wr(4'h9, 0, 0, 32'h40000000);
                i_host.wr(4'h9, 1, 0, 32'h40000000);
                i_host.wr(4'h9, 2, 0, 32'h40000000);
                i_host.wr(4'ha, 1, 0, 32'h00000000);
                // Registers 4 to 7 of page 8 lie below the map and must be ignored
                i_host.wr(4'h8, 0, -1, 32'h40000000);
                stall = 1'b1;
            end
            for (a = 0; a < 4; a++) begin
                for (c = 0; c < 4; c++) begin
                    x = 24'($urandom);
                    if (c == 1) prev1 = x;
                    send(a, 1'b0, 1'b0, 2'(c), x, p ? exp_of(a, c, x) : x);
                end
            end
        end
        stall = 1'b0;
        // Bank switch only in two-channel mode, latched at accept
        x = 24'($urandom);
        send(1, 1'b1, 1'b1, 2'h0, x, x);
        x = 24'($urandom);
        send(1, 1'b0, 1'b1, 2'h0, x, hf(x, 24'sh0));
        x = 24'($urandom);
        send(3, 1'b1, 1'b0, 2'h0, x, hf(hf(x, 24'sh0), 24'sh0));
        x = 24'($urandom);
        send(3, 1'b1, 1'b1, 2'h0, x, hf(x, 24'sh0));
        x = 24'($urandom);
        send(2, 1'b1, 1'b1, 2'h1, x, hf(x, 24'sh0));
        idle();
        // Feedback through section 2: impulse then decay
        i_host.wr(4'h8, 1, 0, 32'h40000000);
        i_host.wr(4'h8, 1, 3, 32'h20000000);
        for (c = 0; c < 4; c++) begin
            x = (c == 0) ? 24'($urandom) : 24'sh0;
            prev1 = hf(x, prev1);
            send(1, 1'b0, 1'b0, 2'h1, x, prev1);
        end
        idle();
        for (c = 0; c < 200 && qd.size() > 0; c++) @(negedge sys_clk_i);
        if (qd.size() > 0) num_errors++;
        results();
    end
endmodule
